//--- hw/ddoi_chan_if.sv
// Purpose: Carries one channel's drive request and diagnostic result
// Assumes: Single aclk domain
// Notes:   Used between top and channel monitors
`timescale 1ns/100ps
interface ddoi_chan_if;
    logic              drive_req;
    logic              open_sync;
    logic              short_sync;
    logic              low_sup;
    ddoi_pkg::ddoi_diag_t code;
    logic              fault;

    modport top (output drive_req, output open_sync, output short_sync,
                 output low_sup, input code, input fault);
    modport mon (input drive_req, input open_sync, input short_sync,
                 input low_sup, output code, output fault);
endinterface : ddoi_chan_if

//--- hw/ddoi_chan_mon.sv
// Purpose: Per-channel diagnostic code generation with debounce
// Assumes: Inputs already synchronised to aclk
// Notes:   Low supply outranks short, short outranks open load
`timescale 1ns/100ps
`include "ddoi_map.svh"
module ddoi_chan_mon (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic image_seen,
    // Channel
    ddoi_chan_if.mon ch
);
    import ddoi_pkg::*;

    localparam int unsigned FILT = `DDOI_FILT_CYC;

    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    ddoi_diag_t  raw_code;
    ddoi_diag_t  code_ff;
    ddoi_diag_t  cand_ff;

    // A fault must hold steady for the filter time so switching edges are not reported
    assign raw_code = ch.low_sup    ? DDOI_DIAG_LOW_SUP :
                      ch.short_sync ? DDOI_DIAG_SHORT :
                      ch.open_sync  ? DDOI_DIAG_NO_LOAD : DDOI_DIAG_OK;
    assign nxt_cnt  = (raw_code != cand_ff) ? 16'h0000 :
                      (cnt_ff == 16'(FILT)) ? cnt_ff : cnt_ff + 16'h0001;

    always_ff @(posedge aclk) begin
        if (!aresetn || !image_seen) begin
            cnt_ff  <= 16'h0000;
            cand_ff <= DDOI_DIAG_OK;
            code_ff <= DDOI_DIAG_OK;
        end else begin
            cnt_ff  <= nxt_cnt;
            cand_ff <= raw_code;
            if (raw_code == cand_ff && cnt_ff == 16'(FILT)) begin
                code_ff <= cand_ff;
            end
        end
    end

    assign ch.code  = code_ff;
    assign ch.fault = (code_ff != DDOI_DIAG_OK);

    chk_code_needs_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        (code_ff == DDOI_DIAG_SHORT && $past(code_ff) != DDOI_DIAG_SHORT)
        |-> $past(cand_ff == DDOI_DIAG_SHORT))
        else $error("short code without short cause");
endmodule : ddoi_chan_mon

//--- hw/ddoi_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 50 MHz aclk, AXI4-Lite 32-bit data
// Notes:   Definitions only
`ifndef DDOI_MAP_SVH
`define DDOI_MAP_SVH

`define DDOI_OFS_OUT_IMG      12'h000
`define DDOI_OFS_DIAG_IMG     12'h004
`define DDOI_OFS_STATUS       12'h008
`define DDOI_OFS_MASK         12'h00c
`define DDOI_OFS_CTRL         12'h010

`define DDOI_OUT_CH1_BIT      0
`define DDOI_OUT_CH2_BIT      1
`define DDOI_DIAG_CH1_LSB     0
`define DDOI_DIAG_CH2_LSB     2

`define DDOI_RST_OUT_IMG      4'h0
`define DDOI_RST_MASK         4'h0
`define DDOI_RST_CTRL         2'h0

`define DDOI_FILT_NS          1000
`define DDOI_CLK_NS           20
`define DDOI_FILT_CYC         ((`DDOI_FILT_NS + `DDOI_CLK_NS - 1) / `DDOI_CLK_NS)

`define DDOI_SUPPLY_FALL_MV   16'd11000
`define DDOI_SUPPLY_RISE_MV   16'd15500

`endif

//--- hw/ddoi_pkg.sv
// Purpose: Types shared by the diagnostic output image block
// Assumes: Offsets and counts live in ddoi_map.svh
// Notes:   Code values follow the per-channel diagnostic encoding
package ddoi_pkg;
    typedef enum logic [1:0] {
        DDOI_DIAG_OK      = 2'b00,
        DDOI_DIAG_NO_LOAD = 2'b01,
        DDOI_DIAG_SHORT   = 2'b10,
        DDOI_DIAG_LOW_SUP = 2'b11
    } ddoi_diag_t;

    typedef enum logic [1:0] {
        DDOI_AXW_IDLE = 2'b00,
        DDOI_AXW_RESP = 2'b01
    } ddoi_axw_t;
endpackage : ddoi_pkg

//--- hw/ddoi_top.sv
// Purpose: Process image of a two-channel digital output with diagnostics
// Assumes: AXI4-Lite coupler side, 50 MHz aclk, field sense pins asynchronous
// Notes:   No address strap or setup; placement fixes the image position
`timescale 1ns/100ps
`include "ddoi_map.svh"
module ddoi_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Field outputs
    output logic             first_output_channel,
    output logic             second_output_channel,
    // Field sense, asynchronous
    input  wire logic [1:0]  open_load_sense,
    input  wire logic [1:0]  short_sense,
    input  wire logic [15:0] field_supply_mv,
    // Interrupt
    output logic             irq
);
    import ddoi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
        addr_is = (a[11:2] == ofs[11:2]);
    endfunction : addr_is

    function automatic logic [3:0] merge_w1c(input logic [3:0] cur, input logic [3:0] set,
                                             input logic [3:0] clr);
        // Hardware set wins over a software clear in the same cycle
        merge_w1c = (cur & ~clr) | set;
    endfunction : merge_w1c

    ////////////////////////////////////////////////////////////////////////////
    // Field input synchronisers

    logic [1:0]  open_s1_ff;
    logic [1:0]  open_s2_ff;
    logic [1:0]  short_s1_ff;
    logic [1:0]  short_s2_ff;
    logic [15:0] sup_s1_ff;
    logic [15:0] sup_s2_ff;
    logic [15:0] sup_s3_ff;

    always_ff @(posedge aclk) begin
        open_s1_ff  <= open_load_sense;
        open_s2_ff  <= open_s1_ff;
        short_s1_ff <= short_sense;
        short_s2_ff <= short_s1_ff;
        sup_s1_ff   <= field_supply_mv;
        sup_s2_ff   <= sup_s1_ff;
        sup_s3_ff   <= sup_s2_ff;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low supply with hysteresis

    logic low_sup_ff;
    logic nxt_low_sup;

    // The supply word crosses many bits at once; act only on two equal samples
    assign nxt_low_sup = (sup_s2_ff != sup_s3_ff) ? low_sup_ff :
                         low_sup_ff ? (sup_s2_ff <= `DDOI_SUPPLY_RISE_MV)
                                    : (sup_s2_ff <  `DDOI_SUPPLY_FALL_MV);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_sup_ff <= 1'b0;
        end else begin
            low_sup_ff <= nxt_low_sup;
        end
    end

    chk_low_sup_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (low_sup_ff && sup_s2_ff > 16'd11000 && sup_s2_ff <= 16'd15500) |=> low_sup_ff)
        else $error("low supply flag dropped inside hysteresis band");

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    logic [3:0]  out_img_ff;
    logic        img_seen_ff;
    logic [3:0]  status_ff;
    logic [3:0]  mask_ff;
    logic [3:0]  diag_img;
    logic [3:0]  diag_prev_ff;
    logic [3:0]  fault_set;
    logic [1:0]  fault_now;

    ddoi_chan_if ch1();
    ddoi_chan_if ch2();

    // Drive only once an image has arrived, so reset leaves the field dark
    assign ch1.drive_req  = out_img_ff[`DDOI_OUT_CH1_BIT] & img_seen_ff;
    assign ch2.drive_req  = out_img_ff[`DDOI_OUT_CH2_BIT] & img_seen_ff;
    assign ch1.open_sync  = open_s2_ff[0];
    assign ch2.open_sync  = open_s2_ff[1];
    assign ch1.short_sync = short_s2_ff[0];
    assign ch2.short_sync = short_s2_ff[1];
    assign ch1.low_sup    = low_sup_ff;
    assign ch2.low_sup    = low_sup_ff;

    ddoi_chan_mon u_mon1 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .image_seen (img_seen_ff),
        .ch         (ch1)
    );

    ddoi_chan_mon u_mon2 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .image_seen (img_seen_ff),
        .ch         (ch2)
    );

    assign diag_img[`DDOI_DIAG_CH1_LSB +: 2] = ch1.code;
    assign diag_img[`DDOI_DIAG_CH2_LSB +: 2] = ch2.code;
    assign fault_now = {ch2.fault, ch1.fault};
    // Events: code change per channel in bits 1:0, new fault entry in bits 3:2
    assign fault_set = {fault_now & ~{diag_prev_ff[3:2] != 2'b00, diag_prev_ff[1:0] != 2'b00},
                        {diag_img[3:2] != diag_prev_ff[3:2], diag_img[1:0] != diag_prev_ff[1:0]}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_output_channel  <= 1'b0;
            second_output_channel <= 1'b0;
            diag_prev_ff          <= 4'h0;
        end else begin
            first_output_channel  <= ch1.drive_req;
            second_output_channel <= ch2.drive_req;
            diag_prev_ff          <= diag_img;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path

    logic        aw_have_ff;
    logic [11:0] aw_addr_ff;
    logic        w_have_ff;
    logic [31:0] w_data_ff;
    logic [3:0]  w_strb_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        wr_go;
    logic        wr_hit;
    logic        wr_out;
    logic        wr_sts;
    logic        wr_msk;
    logic [3:0]  sts_clr;

    assign s_axi_awready = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready  = !w_have_ff && !bvalid_ff;
    assign wr_go  = aw_have_ff && w_have_ff && !bvalid_ff;
    assign wr_out = wr_go && addr_is(aw_addr_ff, `DDOI_OFS_OUT_IMG) && w_strb_ff[0];
    assign wr_sts = wr_go && addr_is(aw_addr_ff, `DDOI_OFS_STATUS) && w_strb_ff[0];
    assign wr_msk = wr_go && addr_is(aw_addr_ff, `DDOI_OFS_MASK) && w_strb_ff[0];
    assign wr_hit = addr_is(aw_addr_ff, `DDOI_OFS_OUT_IMG) || addr_is(aw_addr_ff, `DDOI_OFS_STATUS)
                 || addr_is(aw_addr_ff, `DDOI_OFS_MASK) || addr_is(aw_addr_ff, `DDOI_OFS_DIAG_IMG)
                 || addr_is(aw_addr_ff, `DDOI_OFS_CTRL);
    assign sts_clr = wr_sts ? w_data_ff[3:0] : 4'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            aw_addr_ff <= 12'h000;
            w_have_ff  <= 1'b0;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_ff <= 1'b0;
                w_have_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_hit ? 2'h0 : 2'h2;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // The image register needs no setup before use; any write with wstrb bit 0 set takes effect at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_img_ff  <= `DDOI_RST_OUT_IMG;
            img_seen_ff <= 1'b0;
            mask_ff     <= `DDOI_RST_MASK;
            status_ff   <= 4'h0;
        end else begin
            if (wr_out) begin
                out_img_ff  <= w_data_ff[3:0];
                img_seen_ff <= 1'b1;
            end
            if (wr_msk) begin
                mask_ff <= w_data_ff[3:0];
            end
            status_ff <= merge_w1c(status_ff, fault_set, sts_clr);
        end
    end

    assign irq = |(status_ff & mask_ff);

    chk_out_off_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        !img_seen_ff |-> (!first_output_channel && !second_output_channel && diag_img == 4'h0))
        else $error("output or code active before first image");
    chk_out_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_out ##1 img_seen_ff |=> (first_output_channel == $past(out_img_ff[0], 1)
                                    && second_output_channel == $past(out_img_ff[1], 1)))
        else $error("outputs do not follow image bits 0 and 1");
    chk_status_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (status_ff[0] && !sts_clr[0]) |=> status_ff[0])
        else $error("status bit lost without a clear");

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path

    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic [31:0] rd_mux;
    logic        rd_hit;

    // Output image is write-only and reads as zero
    assign rd_mux = addr_is(s_axi_araddr, `DDOI_OFS_DIAG_IMG) ? {28'h0, diag_img} :
                    addr_is(s_axi_araddr, `DDOI_OFS_STATUS)   ? {28'h0, status_ff} :
                    addr_is(s_axi_araddr, `DDOI_OFS_MASK)     ? {28'h0, mask_ff} :
                    addr_is(s_axi_araddr, `DDOI_OFS_CTRL)     ? {30'h0, low_sup_ff, img_seen_ff} :
                    32'h0000_0000;
    assign rd_hit = addr_is(s_axi_araddr, `DDOI_OFS_DIAG_IMG) || addr_is(s_axi_araddr, `DDOI_OFS_STATUS)
                 || addr_is(s_axi_araddr, `DDOI_OFS_MASK) || addr_is(s_axi_araddr, `DDOI_OFS_CTRL)
                 || addr_is(s_axi_araddr, `DDOI_OFS_OUT_IMG);
    assign s_axi_arready = !rvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_hit ? 2'h0 : 2'h2;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    chk_diag_layout: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && addr_is(s_axi_araddr, 12'h004))
        |=> (s_axi_rdata[3:0] == $past(diag_img)))
        else $error("diagnostic image read mismatch");
    chk_wr_resp_once: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> (s_axi_bvalid && !s_axi_awready))
        else $error("write response missing");
    chk_low_sup_code: assert property (@(posedge aclk) disable iff (!aresetn)
        (ch1.code == DDOI_DIAG_LOW_SUP && $past(ch1.code) != DDOI_DIAG_LOW_SUP)
        |-> $past(low_sup_ff))
        else $error("low supply code without low supply");
endmodule : ddoi_top

//--- tb/ddoi_coupler_model.sv
// Purpose: Coupler-side AXI4-Lite master that exchanges the process image
// Assumes: Single aclk; one write and one read under way at most
// Notes:   Handshakes are judged mid-cycle, then acted on at the next rising edge
`timescale 1ns/100ps
module ddoi_coupler_model (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output logic [11:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // Read channels
    output logic [11:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(negedge aclk);
            ta   = awvalid && awready;
            tw   = wvalid && wready;
            tb   = bvalid;
            resp = bresp;
            @(posedge aclk);
            // Released payload is scrambled so a late sample cannot pass by luck
            if (ta) begin
                awvalid <= 1'b0;
                awaddr  <= ~a;
            end
            if (tw) begin
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
            if (tb) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ta, tr;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(negedge aclk);
            ta   = arvalid && arready;
            tr   = rvalid;
            d    = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
            if (tr) begin
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd
endmodule : ddoi_coupler_model

//--- tb/ddoi_top_test.sv
// Purpose: Self-checking bench for the diagnostic output image block
// Assumes: Field sense held stable long enough for the debounce to settle
// Notes:   Expected codes come from a small priority and hysteresis model
`timescale 1ns/100ps
`include "ddoi_map.svh"
module ddoi_top_test;
    import ddoi_pkg::*;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        first_output_channel, second_output_channel, irq;
    logic [1:0]  open_load_sense = 2'h0;
    logic [1:0]  short_sense = 2'h0;
    logic [15:0] field_supply_mv = 16'h5dc0;
    logic [31:0] seed = 32'h000049bc;
    int          fail_count = 0;
    int          n_checks = 0;
    logic [1:0]  m_op = 2'h0;
    logic [1:0]  m_sh = 2'h0;
    bit          m_seen = 1'b0;
    bit          m_low = 1'b0;

    always #10 aclk = ~aclk;

    ddoi_top DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .first_output_channel(first_output_channel),
        .second_output_channel(second_output_channel),
        .open_load_sense(open_load_sense), .short_sense(short_sense),
        .field_supply_mv(field_supply_mv), .irq(irq)
    );

    ddoi_coupler_model cpl (
        .aclk(aclk), .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
        .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid), .arready(s_axi_arready), .rdata(s_axi_rdata),
        .rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready)
    );

    ////////////////////////////////////////////////////////////////////////////
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [31:0] exp_diag();
        ddoi_diag_t c [2];
        for (int i = 0; i < 2; i++) begin
            c[i] = !m_seen ? DDOI_DIAG_OK : m_low ? DDOI_DIAG_LOW_SUP :
                   m_sh[i] ? DDOI_DIAG_SHORT : m_op[i] ? DDOI_DIAG_NO_LOAD : DDOI_DIAG_OK;
        end
        return {28'h0, c[1], c[0]};
    endfunction : exp_diag

    // Status events: code change per channel in bits 1:0, fresh fault in bits 3:2
    function automatic logic [31:0] exp_sts(input logic [3:0] p, input logic [3:0] n);
        logic [3:0] s;
        s[0] = (p[1:0] != n[1:0]);
        s[1] = (p[3:2] != n[3:2]);
        s[2] = (p[1:0] == 2'b00) && (n[1:0] != 2'b00);
        s[3] = (p[3:2] == 2'b00) && (n[3:2] != 2'b00);
        return {28'h0, s};
    endfunction : exp_sts

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t mismatch: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        cpl.wr(a, d, r);
        chk({30'h0, r}, {30'h0, er});
    endtask : wchk

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        cpl.rd(a, d, r);
        chk({30'h0, r}, {30'h0, er});
        if (er == 2'h0) chk(d, exp);
    endtask : rchk

    // Sense is held well past the sync stages plus the debounce count
    task automatic field(input logic [1:0] op, input logic [1:0] sh, input int mv);
        @(posedge aclk);
        open_load_sense <= op;
        short_sense     <= sh;
        field_supply_mv <= mv[15:0];
        m_op = op;
        m_sh = sh;
        if (mv < 11000) m_low = 1'b1;
        else if (mv > 15500) m_low = 1'b0;
        repeat (`DDOI_FILT_CYC + 20) @(posedge aclk);
    endtask : field

    task automatic pins(input logic [2:0] exp);
        repeat (2) @(negedge aclk);
        chk({29'h0, first_output_channel, second_output_channel, irq}, {29'h0, exp});
    endtask : pins

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done();
    end

    initial begin
        int ops [10] = '{0, 2, 1, 3, 0, 0, 0, 0, 0, 0};
        int shs [10] = '{0, 0, 1, 2, 0, 0, 0, 0, 0, 0};
        int mvs [10] = '{24000, 24000, 24000, 24000, 11000, 10999, 15500, 13000, 15501, 13000};
        logic [31:0] rnd;
        logic [31:0] prv;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        pins(3'b000);
        rchk(`DDOI_OFS_DIAG_IMG, 32'h0, 2'h0);
        rchk(`DDOI_OFS_CTRL, 32'h0, 2'h0);
        field(2'b01, 2'b00, 24000);
        rchk(`DDOI_OFS_DIAG_IMG, exp_diag(), 2'h0);
        $display("test reset done");
        wchk(`DDOI_OFS_MASK, 32'hf, 2'h0);
        wchk(`DDOI_OFS_STATUS, 32'hf, 2'h0);
        wchk(`DDOI_OFS_OUT_IMG, 32'hd, 2'h0);
        m_seen = 1'b1;
        pins(3'b100);
        rchk(`DDOI_OFS_OUT_IMG, 32'h0, 2'h0);
        repeat (`DDOI_FILT_CYC + 20) @(posedge aclk);
        rchk(`DDOI_OFS_DIAG_IMG, exp_diag(), 2'h0);
        rchk(`DDOI_OFS_STATUS, 32'h5, 2'h0);
        pins(3'b101);
        wchk(`DDOI_OFS_MASK, 32'h0, 2'h0);
        pins(3'b100);
        wchk(`DDOI_OFS_MASK, 32'h4, 2'h0);
        pins(3'b101);
        wchk(`DDOI_OFS_STATUS, 32'h5, 2'h0);
        rchk(`DDOI_OFS_STATUS, 32'h0, 2'h0);
        pins(3'b100);
        $display("test irq done");
        for (int i = 0; i < 10; i++) begin
            prv = exp_diag();
            wchk(`DDOI_OFS_STATUS, 32'hf, 2'h0);
            field(ops[i][1:0], shs[i][1:0], mvs[i]);
            rchk(`DDOI_OFS_DIAG_IMG, exp_diag(), 2'h0);
            rchk(`DDOI_OFS_STATUS, exp_sts(prv[3:0], exp_diag()), 2'h0);
            rchk(`DDOI_OFS_CTRL, {30'h0, m_low, 1'b1}, 2'h0);
        end
        $display("test diag done");
        for (int i = 0; i < 8; i++) begin
            rnd = xs();
            wchk(`DDOI_OFS_OUT_IMG, rnd, 2'h0);
            pins({rnd[0], rnd[1], 1'b0});
        end
        $display("test output done");
        wchk(12'h100, 32'h1, 2'h2);
        rchk(12'h100, 32'h0, 2'h2);
        $display("test unmapped done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        m_seen = 1'b0;
        pins(3'b000);
        rchk(`DDOI_OFS_DIAG_IMG, 32'h0, 2'h0);
        $display("test second reset done");
        test_done();
    end
endmodule : ddoi_top_test
